// [rtl/tmr_pkg.sv]
// Shared constants and types for the 8-bit timer with compare output
package tmr_pkg;

    // Register byte offsets on the AHB-Lite bus
    localparam logic [7:0] TMR_OFS_CTRL = 8'h00;
    localparam logic [7:0] TMR_OFS_COUNT = 8'h04;
    localparam logic [7:0] TMR_OFS_COMPARE = 8'h08;
    localparam logic [7:0] TMR_OFS_FLAGS = 8'h0C;
    localparam logic [7:0] TMR_OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] TMR_OFS_STATUS = 8'h14;

    // Control register field positions
    localparam int TMR_CS_LSB = 0;
    localparam int TMR_WGM_LSB = 3;
    localparam int TMR_COM_LSB = 5;
    localparam int TMR_FOC_BIT = 7;

    // Flag and interrupt enable bit positions
    localparam int TMR_OVF_BIT = 0;
    localparam int TMR_CMP_BIT = 1;

    // Status register field positions
    localparam int TMR_ST_OC_BIT = 0;
    localparam int TMR_ST_DOWN_BIT = 1;
    localparam int TMR_ST_BLOCK_BIT = 2;
    localparam int TMR_ST_OCR_LSB = 8;

    // Waveform generation mode encodings
    localparam logic [1:0] TMR_WGM_NORMAL = 2'h0;
    localparam logic [1:0] TMR_WGM_PHASE = 2'h1;
    localparam logic [1:0] TMR_WGM_CTC = 2'h2;
    localparam logic [1:0] TMR_WGM_FAST = 2'h3;

    // Compare output action encodings
    localparam logic [1:0] TMR_COM_NONE = 2'h0;
    localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TMR_COM_CLEAR = 2'h2;
    localparam logic [1:0] TMR_COM_SET = 2'h3;

    // Clock source select encodings
    localparam logic [2:0] TMR_CS_STOP = 3'h0;
    localparam logic [2:0] TMR_CS_DIV1 = 3'h1;
    localparam logic [2:0] TMR_CS_DIV8 = 3'h2;
    localparam logic [2:0] TMR_CS_DIV64 = 3'h3;
    localparam logic [2:0] TMR_CS_DIV256 = 3'h4;
    localparam logic [2:0] TMR_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TMR_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TMR_CS_EXT_RISE = 3'h7;

    // Prescaler terminal masks, one per division ratio above 1
    localparam int TMR_PRE_W = 10;
    localparam logic [9:0] TMR_PRE_MASK8 = 10'h007;
    localparam logic [9:0] TMR_PRE_MASK64 = 10'h03F;
    localparam logic [9:0] TMR_PRE_MASK256 = 10'h0FF;
    localparam logic [9:0] TMR_PRE_MASK1024 = 10'h3FF;

    // Counter extremes
    localparam logic [7:0] TMR_BOTTOM = 8'h00;
    localparam logic [7:0] TMR_MAX = 8'hFF;

    // AHB transfer type and response codes
    localparam logic [1:0] TMR_HTRANS_NONSEQ = 2'h2;
    localparam logic TMR_HRESP_OKAY = 1'b0;

    // Complete state of the timer core
    typedef struct packed {
        logic [2:0] clock_source_select;
        logic [1:0] waveform_mode_select;
        logic [1:0] compare_output_action;
        logic [7:0] counter_value;
        logic [7:0] compare_value_reg;
        logic [7:0] compare_buffer;
        logic count_down;
        logic match_block;
        logic compare_output_state;
        logic overflow_flag;
        logic compare_match_flag;
        logic overflow_irq_enable;
        logic compare_irq_enable;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic ready;
        logic overflow_irq;
        logic compare_irq;
        logic pin_out;
        logic pin_oe;
    } tmr_state_t;

    // State of the tick generator
    typedef struct packed {
        logic [TMR_PRE_W-1:0] prescale;
        logic ext_meta;
        logic ext_sync;
        logic ext_prev;
        logic tick;
    } tmr_tick_state_t;

endpackage

// [rtl/tmr_tick_gen.sv]
// Timer tick generator: prescaler and external edge source
`timescale 1ns/1ps
`default_nettype none

module tmr_tick_gen
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Source selection and external pin
    input wire logic [2:0] clock_source_select,
    input wire logic ext_tick_pin,
    // One-cycle timer tick
    output logic timer_tick
);

    tmr_tick_state_t q;
    tmr_tick_state_t d;

    // Prescaler free-runs; selection picks stop, every cycle, one terminal count or an edge
    always_comb begin
        d = q;
        d.prescale = q.prescale + 10'h001;
        d.ext_meta = ext_tick_pin;
        d.ext_sync = q.ext_meta;
        d.ext_prev = q.ext_sync;
        case (clock_source_select)
            TMR_CS_STOP: d.tick = 1'b0;
            TMR_CS_DIV1: d.tick = 1'b1;
            TMR_CS_DIV8: d.tick = (q.prescale & TMR_PRE_MASK8) == TMR_PRE_MASK8;
            TMR_CS_DIV64: d.tick = (q.prescale & TMR_PRE_MASK64) == TMR_PRE_MASK64;
            TMR_CS_DIV256: d.tick = (q.prescale & TMR_PRE_MASK256) == TMR_PRE_MASK256;
            TMR_CS_DIV1024: d.tick = q.prescale == TMR_PRE_MASK1024;
            TMR_CS_EXT_FALL: d.tick = q.ext_prev & ~q.ext_sync;
            TMR_CS_EXT_RISE: d.tick = ~q.ext_prev & q.ext_sync;
            default: d.tick = 1'b0;
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign timer_tick = q.tick;

endmodule

`default_nettype wire

// [rtl/tmr_core.sv]
// 8-bit timer: counter, comparator, compare output unit and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none

module tmr_core
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // CPU side interrupt handshake
    input wire logic global_irq_enable,
    input wire logic overflow_irq_ack,
    input wire logic compare_irq_ack,
    output logic overflow_irq,
    output logic compare_irq,
    // External tick pin
    input wire logic ext_tick_pin,
    // Port pin
    input wire logic output_pin_direction,
    input wire logic port_data,
    output logic pin_out,
    output logic pin_oe
);

    tmr_state_t q;
    tmr_state_t d;
    // Registered tick, one cycle wide
    logic timer_tick;

    // True in either PWM mode, where the compare value is buffered
    function automatic logic is_pwm(input logic [1:0] wgm);
        is_pwm = (wgm == TMR_WGM_PHASE) || (wgm == TMR_WGM_FAST);
    endfunction

    // Count at its maximum
    function automatic logic at_max(input logic [7:0] cnt);
        at_max = cnt == TMR_MAX;
    endfunction

    // Output state after a compare match for the given mode and action
    function automatic logic match_action(input logic [1:0] wgm, input logic [1:0] com,
                                          input logic oc, input logic down);
        logic r;
        r = oc;
        case (com)
            TMR_COM_NONE: r = oc;
            TMR_COM_TOGGLE: r = (wgm == TMR_WGM_PHASE) ? oc : ~oc;
            TMR_COM_CLEAR: r = (wgm == TMR_WGM_PHASE) ? down : 1'b0;
            TMR_COM_SET: r = (wgm == TMR_WGM_PHASE) ? ~down : 1'b1;
            default: r = oc;
        endcase
        match_action = r;
    endfunction

    // Register read decode
    function automatic logic [31:0] read_reg(input logic [7:0] addr, input tmr_state_t s);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (addr)
            TMR_OFS_CTRL: begin
                r[TMR_CS_LSB +: 3] = s.clock_source_select;
                r[TMR_WGM_LSB +: 2] = s.waveform_mode_select;
                r[TMR_COM_LSB +: 2] = s.compare_output_action;
            end
            TMR_OFS_COUNT: r[7:0] = s.counter_value;
            TMR_OFS_COMPARE: r[7:0] = s.compare_buffer;
            TMR_OFS_FLAGS: begin
                r[TMR_OVF_BIT] = s.overflow_flag;
                r[TMR_CMP_BIT] = s.compare_match_flag;
            end
            TMR_OFS_IRQ_EN: begin
                r[TMR_OVF_BIT] = s.overflow_irq_enable;
                r[TMR_CMP_BIT] = s.compare_irq_enable;
            end
            TMR_OFS_STATUS: begin
                r[TMR_ST_OC_BIT] = s.compare_output_state;
                r[TMR_ST_DOWN_BIT] = s.count_down;
                r[TMR_ST_BLOCK_BIT] = s.match_block;
                r[TMR_ST_OCR_LSB +: 8] = s.compare_value_reg;
            end
            default: r = 32'h0000_0000;
        endcase
        read_reg = r;
    endfunction

    // Tick source
    tmr_tick_gen tmr_tick_gen_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .clock_source_select(q.clock_source_select),
        .ext_tick_pin(ext_tick_pin),
        .timer_tick(timer_tick)
    );

    // Next-state logic
    always_comb begin
        logic take;
        logic match;
        logic set_ovf;
        logic set_cmp;
        logic [7:0] wr_byte;
        logic [1:0] new_wgm;
        logic [1:0] new_com;
        take = 1'b0;
        match = 1'b0;
        set_ovf = 1'b0;
        set_cmp = 1'b0;
        wr_byte = hwdata[7:0];
        new_wgm = hwdata[TMR_WGM_LSB +: 2];
        new_com = hwdata[TMR_COM_LSB +: 2];
        d = q;
        d.dp_write = 1'b0;
        d.ready = 1'b1;

        // Address phase: capture write intent, prefetch read data
        // NONSEQ or SEQ starts a transfer
        take = hsel && hready && (htrans == TMR_HTRANS_NONSEQ || htrans == 2'h3);
        if (take) begin
            d.dp_write = hwrite;
            d.dp_addr = {haddr[7:2], 2'h0};
            d.rdata = hwrite ? 32'h0000_0000 : read_reg({haddr[7:2], 2'h0}, q);
        end

        // Flag clears by software write of one or by interrupt service
        // Any set further down wins
        if (q.dp_write && q.dp_addr == TMR_OFS_FLAGS) begin
            if (hwdata[TMR_OVF_BIT]) begin
                d.overflow_flag = 1'b0;
            end
            if (hwdata[TMR_CMP_BIT]) begin
                d.compare_match_flag = 1'b0;
            end
        end
        if (overflow_irq_ack) begin
            d.overflow_flag = 1'b0;
        end
        if (compare_irq_ack) begin
            d.compare_match_flag = 1'b0;
        end

        // Counter unit, only on a timer tick
        if (timer_tick) begin
            // Count before this tick
            match = (q.counter_value == q.compare_value_reg) && !q.match_block;
            d.match_block = 1'b0;
            case (q.waveform_mode_select)
                // Normal: up only
                TMR_WGM_NORMAL: begin
                    d.counter_value = q.counter_value + 8'h01;
                    set_ovf = at_max(q.counter_value);
                end

                // Clear on match
                TMR_WGM_CTC: begin
                    if (match) begin
                        d.counter_value = TMR_BOTTOM;
                    end else begin
                        d.counter_value = q.counter_value + 8'h01;
                        set_ovf = at_max(q.counter_value);
                    end
                end

                // Fast PWM: single slope
                TMR_WGM_FAST: begin
                    // Wrap to bottom
                    if (at_max(q.counter_value)) begin
                        d.counter_value = TMR_BOTTOM;
                        set_ovf = 1'b1;
                        d.compare_value_reg = q.compare_buffer;
                        if (q.compare_output_action[1]) begin
                            d.compare_output_state = ~q.compare_output_action[0];
                        end
                    end else begin
                        d.counter_value = q.counter_value + 8'h01;
                    end
                end

                // Phase PWM: dual slope
                TMR_WGM_PHASE: begin
                    if (!q.count_down) begin
                        // Turn at max
                        if (at_max(q.counter_value)) begin
                            d.count_down = 1'b1;
                            d.counter_value = q.counter_value - 8'h01;
                            d.compare_value_reg = q.compare_buffer;
                        end else begin
                            d.counter_value = q.counter_value + 8'h01;
                        end
                    end else begin
                        // Turn at bottom
                        if (q.counter_value == TMR_BOTTOM) begin
                            d.count_down = 1'b0;
                            d.counter_value = q.counter_value + 8'h01;
                            set_ovf = 1'b1;
                        end else begin
                            d.counter_value = q.counter_value - 8'h01;
                        end
                    end
                end

                // All codes decoded above
                default: d.counter_value = q.counter_value;
            endcase
            // After any bottom action
            if (match) begin
                set_cmp = 1'b1;
                d.compare_output_state = match_action(q.waveform_mode_select,
                    q.compare_output_action, q.compare_output_state, q.count_down);
            end
        end

        // Hardware sets win over clears in the same cycle
        if (set_ovf) begin
            d.overflow_flag = 1'b1;
        end
        if (set_cmp) begin
            d.compare_match_flag = 1'b1;
        end

        // Data phase writes, after the counter so they take priority
        if (q.dp_write) begin
            case (q.dp_addr)
                // Control fields and force
                TMR_OFS_CTRL: begin
                    d.clock_source_select = hwdata[TMR_CS_LSB +: 3];
                    d.waveform_mode_select = new_wgm;
                    d.compare_output_action = new_com;
                    // Down count only in phase PWM
                    if (new_wgm != TMR_WGM_PHASE) begin
                        d.count_down = 1'b0;
                    end
                    // Force: non-PWM modes only
                    if (hwdata[TMR_FOC_BIT] && !is_pwm(new_wgm)) begin
                        d.compare_output_state = match_action(new_wgm, new_com,
                            d.compare_output_state, 1'b0);
                    end
                end

                // Write beats this tick
                TMR_OFS_COUNT: begin
                    d.counter_value = wr_byte;
                    d.match_block = 1'b1;
                end

                // PWM waits for top or bottom
                TMR_OFS_COMPARE: begin
                    d.compare_buffer = wr_byte;
                    if (!is_pwm(q.waveform_mode_select)) begin
                        d.compare_value_reg = wr_byte;
                    end
                end

                // Interrupt enables
                TMR_OFS_IRQ_EN: begin
                    d.overflow_irq_enable = hwdata[TMR_OVF_BIT];
                    d.compare_irq_enable = hwdata[TMR_CMP_BIT];
                end

                // Flags (cleared above), status or unmapped
                default: d.dp_addr = q.dp_addr;
            endcase
        end

        // Interrupt requests
        // One cycle after the cause
        d.overflow_irq = d.overflow_flag && d.overflow_irq_enable && global_irq_enable;
        d.compare_irq = d.compare_match_flag && d.compare_irq_enable
            && global_irq_enable;

        // Port override: action bits choose the source, direction gates it
        // Input pin held low
        d.pin_oe = output_pin_direction;
        if (d.compare_output_action != TMR_COM_NONE) begin
            d.pin_out = output_pin_direction && d.compare_output_state;
        end else begin
            d.pin_out = output_pin_direction && port_data;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register; hresp tied to OKAY
    assign hrdata = q.rdata;
    assign hreadyout = q.ready;
    assign hresp = TMR_HRESP_OKAY;
    assign overflow_irq = q.overflow_irq;
    assign compare_irq = q.compare_irq;
    assign pin_out = q.pin_out;
    assign pin_oe = q.pin_oe;

    // Transfer size is not checked: every access is a whole word
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0], hwdata[31:8]};

endmodule

`default_nettype wire

// [verification/tmr_core_sva.sv]
// Port checker for the timer core
`timescale 1ns/1ps
`default_nettype none
module tmr_core_sva (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Interrupts and pin
    input wire logic global_irq_enable,
    input wire logic overflow_irq,
    input wire logic compare_irq,
    input wire logic output_pin_direction,
    input wire logic pin_out,
    input wire logic pin_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Bus answers
    a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
    a_zero_wait: assert property ($past(hresetn, 2) |-> hreadyout)
        else $error("wait state seen");
    a_read_holds: assert property (!(hsel && hready && htrans[1]) |=>
        $stable(hrdata)) else $error("read data moved");
    a_write_zero: assert property (hsel && hready && htrans[1] && hwrite |=>
        hrdata == 32'h0) else $error("write data phase not zero");
    a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    // Pin and interrupt outputs
    a_oe_direction: assert property ($past(hresetn) |->
        pin_oe == $past(output_pin_direction)) else $error("enable not direction");
    a_input_quiet: assert property (!pin_oe |-> !pin_out)
        else $error("pin driven as input");
    a_cmp_gated: assert property (!global_irq_enable |=> !compare_irq)
        else $error("compare irq without global");
    a_ovf_gated: assert property (overflow_irq |-> $past(global_irq_enable))
        else $error("overflow irq without global");
    a_reset_state: assert property ($rose(hresetn) |-> !pin_out && !compare_irq)
        else $error("outputs not cleared by reset");
    // Main scenarios
    c_cmp_irq: cover property ($rose(compare_irq));
    c_ovf_irq: cover property ($rose(overflow_irq));
    c_pin_high: cover property ($rose(pin_out));
endmodule

bind tmr_core tmr_core_sva tmr_core_sva_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .global_irq_enable(global_irq_enable),
    .overflow_irq(overflow_irq), .compare_irq(compare_irq),
    .output_pin_direction(output_pin_direction), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// [verification/tmr_cpu_model.sv]
// CPU side model: services timer interrupts after a set delay
`timescale 1ns/1ps
`default_nettype none
module tmr_cpu_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Service latency in cycles
    input wire logic [3:0] svc_delay,
    // Requests (0 overflow, 1 compare) and acknowledges
    input wire logic [1:0] irq,
    output logic [1:0] ack
);
    logic [1:0][3:0] wait_q;
    logic [1:0] done_q;
    // One acknowledge pulse per request, after the service delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_q <= '0;
            done_q <= '0;
            ack <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ack[i] <= 1'b0;
                if (!irq[i]) begin
                    wait_q[i] <= 4'h0;
                    done_q[i] <= 1'b0;
                end else if (!done_q[i] && wait_q[i] == svc_delay) begin
                    ack[i] <= 1'b1;
                    done_q[i] <= 1'b1;
                end else if (!done_q[i]) begin
                    wait_q[i] <= wait_q[i] + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verification/tmr_core_bench.sv]
// Self-checking bench for the timer core
`timescale 1ns/1ps
`default_nettype none
module tmr_core_bench import tmr_pkg::*;;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic gie = 1'b0;
    logic dir = 1'b0;
    logic port_data = 1'b0;
    logic ext_pin = 1'b0;
    logic [3:0] svc_delay = 4'h0;
    logic [31:0] hrdata, x;
    logic hreadyout, hresp, pin_out, pin_oe;
    logic [1:0] irq, ack;
    int n_errors = 0;
    int n_tests = 0;
    // 40 MHz clock
    always #12.5 hclk = ~hclk;
    tmr_core tmr_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .global_irq_enable(gie), .overflow_irq_ack(ack[0]), .compare_irq_ack(ack[1]),
        .overflow_irq(irq[0]), .compare_irq(irq[1]), .ext_tick_pin(ext_pin),
        .output_pin_direction(dir), .port_data(port_data), .pin_out(pin_out),
        .pin_oe(pin_oe));
    tmr_cpu_model tmr_cpu_model_inst (.hclk(hclk), .hresetn(hresetn),
        .svc_delay(svc_delay), .irq(irq), .ack(ack));
    // Verdict and end of run
    task automatic results();
        $display("tests %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_hready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: bus hang", $time);
            results();
        end
    endtask
    // One single word transfer; read data left in x
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= TMR_HTRANS_NONSEQ;
        wait_hready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_hready();
        x = hrdata;
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(x & m, e);
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] m,
        input logic [1:0] com, input logic foc);
        return {24'h0, foc, com, m, cs};
    endfunction
    // Bounded wait for an interrupt line to reach a level
    task automatic wait_irq(input int i, input logic lvl);
        int n;
        n = 0;
        while (irq[i] !== lvl && n < 40) begin
            @(posedge hclk);
            n++;
        end
        check(32'(irq[i]), 32'(lvl));
        if (irq[i] !== lvl) results();
    endtask
    // Run the timer from the /1 source for a few cycles, then stop it
    task automatic run(input logic [1:0] m, input int cyc);
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_DIV1, m, TMR_COM_NONE, 1'b0));
        repeat (cyc) @(posedge hclk);
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, m, TMR_COM_NONE, 1'b0));
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values and unmapped space
        rdm(TMR_OFS_CTRL, ALL, 32'h0);
        rdm(TMR_OFS_COUNT, ALL, 32'h0);
        rdm(TMR_OFS_STATUS, ALL, 32'h0);
        check(32'({pin_oe, pin_out}), 32'h0);
        bus(1'b1, 8'h1C, ALL);
        rdm(8'h1C, ALL, 32'h0);
        $display("reset test done");
        // Stopped timer keeps a written count; write blocks an equal match
        bus(1'b1, TMR_OFS_COMPARE, 32'h5A);
        bus(1'b1, TMR_OFS_COUNT, 32'h5A);
        repeat (10) @(posedge hclk);
        rdm(TMR_OFS_COUNT, ALL, 32'h5A);
        run(TMR_WGM_NORMAL, 3);
        rdm(TMR_OFS_FLAGS, ALL, 32'h0);
        bus(1'b0, TMR_OFS_COUNT, 32'h0);
        check(32'(x[7:0] > 8'h5A), 32'h1);
        check(32'(x[7:0] < 8'h62), 32'h1);
        $display("block test done");
        // Normal mode wrap sets overflow; partner services it promptly
        bus(1'b1, TMR_OFS_COUNT, 32'hFE);
        run(TMR_WGM_NORMAL, 4);
        rdm(TMR_OFS_FLAGS, ALL, 32'h1);
        bus(1'b0, TMR_OFS_COUNT, 32'h0);
        check(32'(x[7:0] < 8'h10), 32'h1);
        bus(1'b1, TMR_OFS_IRQ_EN, 32'h3);
        repeat (3) @(posedge hclk);
        check(32'(irq[0]), 32'h0);
        gie <= 1'b1;
        wait_irq(0, 1'b1);
        wait_irq(0, 1'b0);
        rdm(TMR_OFS_FLAGS, ALL, 32'h0);
        $display("overflow test done");
        // Clear-on-match keeps the count at or below the compare value
        gie <= 1'b0;
        svc_delay <= 4'hF;
        bus(1'b1, TMR_OFS_COMPARE, 32'h3);
        bus(1'b1, TMR_OFS_COUNT, 32'h0);
        run(TMR_WGM_CTC, 20);
        bus(1'b0, TMR_OFS_COUNT, 32'h0);
        check(32'(x[7:0] <= 8'h3), 32'h1);
        rdm(TMR_OFS_FLAGS, ALL, 32'h2);
        check(32'(irq[1]), 32'h0);
        gie <= 1'b1;
        wait_irq(1, 1'b1);
        bus(1'b1, TMR_OFS_FLAGS, 32'h2);
        wait_irq(1, 1'b0);
        rdm(TMR_OFS_FLAGS, ALL, 32'h0);
        gie <= 1'b0;
        $display("compare test done");
        // Compare output unit and pin override
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_SET, 1'b1));
        rdm(TMR_OFS_CTRL, ALL, ctl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_SET, 1'b0));
        rdm(TMR_OFS_STATUS, 32'h1, 32'h1);
        rdm(TMR_OFS_FLAGS, ALL, 32'h0);
        check(32'({pin_oe, pin_out}), 32'h0);
        dir <= 1'b1;
        repeat (2) @(posedge hclk);
        check(32'({pin_oe, pin_out}), 32'h3);
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, TMR_WGM_CTC, TMR_COM_TOGGLE, 1'b1));
        rdm(TMR_OFS_STATUS, 32'h1, 32'h0);
        port_data <= 1'b1;
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, TMR_WGM_CTC, TMR_COM_NONE, 1'b1));
        rdm(TMR_OFS_STATUS, 32'h1, 32'h0);
        check(32'(pin_out), 32'h1);
        port_data <= 1'b0;
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_SET, 1'b1));
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, TMR_WGM_FAST, TMR_COM_CLEAR, 1'b0));
        rdm(TMR_OFS_STATUS, 32'h1, 32'h1);
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, TMR_WGM_FAST, TMR_COM_TOGGLE, 1'b1));
        rdm(TMR_OFS_STATUS, 32'h1, 32'h1);
        check(32'(pin_out), 32'h1);
        dir <= 1'b0;
        $display("output test done");
        // Every source and mode code reads back
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, TMR_OFS_CTRL, ctl(3'(c), 2'(c), TMR_COM_NONE, 1'b0));
            rdm(TMR_OFS_CTRL, ALL, ctl(3'(c), 2'(c), TMR_COM_NONE, 1'b0));
        end
        // Compare buffering in fast PWM mode
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
        bus(1'b1, TMR_OFS_COMPARE, 32'h10);
        rdm(TMR_OFS_STATUS, 32'hFF00, 32'h1000);
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_STOP, TMR_WGM_FAST, TMR_COM_NONE, 1'b0));
        bus(1'b1, TMR_OFS_COMPARE, 32'h80);
        rdm(TMR_OFS_STATUS, 32'hFF00, 32'h1000);
        rdm(TMR_OFS_COMPARE, ALL, 32'h80);
        bus(1'b1, TMR_OFS_COUNT, 32'hFD);
        run(TMR_WGM_FAST, 4);
        rdm(TMR_OFS_STATUS, 32'hFF00, 32'h8000);
        $display("buffer test done");
        // External rising edges, one tick each
        bus(1'b1, TMR_OFS_COUNT, 32'h0);
        bus(1'b1, TMR_OFS_CTRL, ctl(TMR_CS_EXT_RISE, TMR_WGM_NORMAL, TMR_COM_NONE, 1'b0));
        repeat (6) begin
            repeat (6) @(posedge hclk);
            ext_pin <= ~ext_pin;
        end
        rdm(TMR_OFS_COUNT, ALL, 32'h3);
        $display("external test done");
        results();
    end
endmodule
`default_nettype wire
